// ==== rtl/rcpw_pkg.sv ====
// Package: constants, register map and carriers for reset cause and periodic wake
// Functional notes
// - Low supply with detect and irq enabled, reset disabled, sets flag and interrupts.
// - Periodic timer ticks from 1 kHz reference or 32 kHz divided by 32.
// - Clock-select bit in periodic control register picks the tick source.
// - The 1 kHz reference stays usable in run, wait and stop; 32 kHz is gated in stop.
// - 32 kHz runs in stop only if detect and stop-enable set before stop.
// - Three-bit rate field selects seven periods or turns the timer off.
// - Periodic register has read-only flag and write-only acknowledge bit.
// - Periodic irq enable bit masks the periodic interrupt when clear.
// - Rate field all zero disables timer; no interrupts are produced.
// - Debug forced reset command clears every cause bit.
// - Any write to cause register clears watchdog, contents unchanged.
// - Power-on reset sets cause bits 7 and 1, clears the rest.
// - Low-supply reset with reset enable sets cause bit 1 only.
// - Other resets set active pin/watchdog/opcode/address bits, clear others.
// - Bit 6 set when active-low reset pin caused the reset.
// - Bit 5 records watchdog reset; none while watchdog enable is 0.
// - Bit 4 records illegal opcode, disallowed stop or disallowed debug halt.
// - Bit 3 records access to an unimplemented address.
package rcpw_pkg;
  // ----------------------------------------
  // Register byte addresses
  // ----------------------------------------
  localparam logic [4:0] ADDR_CAUSE = 5'h00;
  localparam logic [4:0] ADDR_POWER = 5'h04;
  localparam logic [4:0] ADDR_PWAKE = 5'h08;
  localparam logic [4:0] ADDR_IRQ_STATUS = 5'h0c;
  localparam logic [4:0] ADDR_IRQ_MASK = 5'h10;
  // ----------------------------------------
  // Cause bit positions
  // ----------------------------------------
  localparam int CAUSE_POWER_ON = 7;
  localparam int CAUSE_PIN = 6;
  localparam int CAUSE_WATCHDOG = 5;
  localparam int CAUSE_OPCODE = 4;
  localparam int CAUSE_ADDRESS = 3;
  localparam int CAUSE_LOW_SUPPLY = 1;
  localparam logic [7:0] CAUSE_AT_POWER_ON = 8'h82;
  localparam logic [7:0] CAUSE_AT_LOW_SUPPLY = 8'h02;
  localparam logic [7:0] CAUSE_NONE = 8'h00;
  // ----------------------------------------
  // Field positions shared by both control registers
  // ----------------------------------------
  localparam int FLAG_BIT = 7;
  localparam int ACK_BIT = 6;
  // ----------------------------------------
  // Interrupt status bits
  // ----------------------------------------
  localparam int IRQ_LOW_SUPPLY = 0;
  localparam int IRQ_PERIODIC = 1;
  // ----------------------------------------
  // Periodic timer
  // ----------------------------------------
  localparam logic [4:0] DIV32_LAST = 5'h1f;
  localparam logic [2:0] RATE_OFF = 3'h0;
  localparam logic [10:0] PERIOD_LAST_R1 = 11'h007;
  localparam logic [10:0] PERIOD_LAST_R2 = 11'h01f;
  localparam logic [10:0] PERIOD_LAST_R3 = 11'h03f;
  localparam logic [10:0] PERIOD_LAST_R4 = 11'h07f;
  localparam logic [10:0] PERIOD_LAST_R5 = 11'h0ff;
  localparam logic [10:0] PERIOD_LAST_R6 = 11'h1ff;
  localparam logic [10:0] PERIOD_LAST_R7 = 11'h3ff;
  // ----------------------------------------
  // Carriers
  // ----------------------------------------
  typedef struct packed {
    logic irq_enable;
    logic reset_enable;
    logic stop_enable;
    logic detect_enable;
  } rcpw_power_t;
  typedef struct packed {
    logic clock_select;
    logic irq_enable;
    logic [2:0] rate;
  } rcpw_pwake_t;
  localparam rcpw_power_t POWER_RESET = '{1'b0, 1'b1, 1'b0, 1'b1};
  localparam rcpw_pwake_t PWAKE_RESET = '{1'b0, 1'b0, 3'h0};
endpackage

// ==== rtl/rcpw_top.sv ====
// Reset cause register, low-supply interrupt path and periodic wake timer
//
// Implementation choices: the Avalon-MM slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module rcpw_top (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic irq,
  input wire logic pin_reset_n,
  input wire logic supply_low,
  input wire logic ref_1khz,
  input wire logic ref_32khz,
  input wire logic reset_pin_enable,
  input wire logic watchdog_enable,
  input wire logic watchdog_timeout,
  input wire logic bad_opcode,
  input wire logic stop_instr,
  input wire logic stop_allow,
  input wire logic debug_halt_instr,
  input wire logic debug_halt_allow,
  input wire logic bad_address,
  input wire logic debug_forced_reset_cmd,
  input wire logic stop_mode,
  output logic system_reset,
  output logic watchdog_clear,
  output logic lowsupply_flag
);
  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  localparam int NSYNC = 4;
  // The reset pin idles high; clearing its stages would fake a pin reset at release
  localparam logic [NSYNC-1:0] SYNC_IDLE = 4'h1;
  logic [NSYNC-1:0] async_in;
  logic [NSYNC-1:0] sync_a;
  logic [NSYNC-1:0] sync_b;
  logic [NSYNC-1:0] sync_c;
  assign async_in = {ref_32khz, ref_1khz, supply_low, pin_reset_n};
  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi++) begin : g_sync
      always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
          sync_a[gi] <= SYNC_IDLE[gi];
          sync_b[gi] <= SYNC_IDLE[gi];
          sync_c[gi] <= SYNC_IDLE[gi];
        end else begin
          sync_a[gi] <= async_in[gi];
          sync_b[gi] <= sync_a[gi];
          sync_c[gi] <= sync_b[gi];
        end
      end
    end
  endgenerate
  wire pin_low = ~sync_b[0];
  wire supply_is_low = sync_b[1];
  wire rise_1k = sync_b[2] & ~sync_c[2];
  wire rise_32k = sync_b[3] & ~sync_c[3];

  // ----------------------------------------
  // Bus slave: one wait state on every access
  // ----------------------------------------
  logic served;
  wire req = avs_read | avs_write;
  assign avs_waitrequest = req & ~served;
  wire lane0 = avs_byteenable[0];
  wire do_wr = avs_write & served & lane0;
  wire do_rd = avs_read & served;
  wire hit_cause = avs_address == rcpw_pkg::ADDR_CAUSE;
  wire hit_power = avs_address == rcpw_pkg::ADDR_POWER;
  wire hit_pwake = avs_address == rcpw_pkg::ADDR_PWAKE;
  wire hit_istat = avs_address == rcpw_pkg::ADDR_IRQ_STATUS;
  wire hit_imask = avs_address == rcpw_pkg::ADDR_IRQ_MASK;
  wire wr_power = do_wr & hit_power;
  wire wr_pwake = do_wr & hit_pwake;
  wire wr_imask = do_wr & hit_imask;
  wire rd_istat = do_rd & hit_istat;

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [7:0] cause;
  rcpw_pkg::rcpw_power_t power;
  rcpw_pkg::rcpw_pwake_t pwake;
  logic pwake_flag;
  logic [1:0] irq_status;
  logic [1:0] irq_mask;
  logic [7:0] next_readdata;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      served <= 1'b0;
      avs_readdata <= 32'h0000_0000;
    end else begin
      served <= req & ~served;
      avs_readdata <= {24'h00_0000, next_readdata};
    end
  end

  // Acknowledge bits are write-only and read back as zero
  wire [7:0] power_rd = {lowsupply_flag, 1'b0, power, 2'b00};
  wire [7:0] pwake_rd = {pwake_flag, 1'b0, pwake.clock_select, pwake.irq_enable,
                         1'b0, pwake.rate};
  assign next_readdata = hit_cause ? cause :
                         hit_power ? power_rd :
                         hit_pwake ? pwake_rd :
                         hit_istat ? {6'h00, irq_status} :
                         hit_imask ? {6'h00, irq_mask} : 8'h00;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      power <= rcpw_pkg::POWER_RESET;
      pwake <= rcpw_pkg::PWAKE_RESET;
      irq_mask <= 2'b00;
    end else begin
      if (wr_power) begin
        power <= avs_writedata[5:2];
      end
      if (wr_pwake) begin
        pwake <= {avs_writedata[5:4], avs_writedata[2:0]};
      end
      if (wr_imask) begin
        irq_mask <= avs_writedata[1:0];
      end
    end
  end

  // ----------------------------------------
  // Watchdog clear on any write to the cause address
  // ----------------------------------------
  // Byte lanes do not matter here: the act of writing is what counts
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      watchdog_clear <= 1'b0;
    end else begin
      watchdog_clear <= avs_write & served & hit_cause;
    end
  end

  // ----------------------------------------
  // Reset cause capture
  // ----------------------------------------
  // rst_n is the power-on reset; other system resets are requested from here
  // and the cause register survives them.
  wire supply_reset = power.detect_enable & power.reset_enable & supply_is_low;
  wire src_pin = reset_pin_enable & pin_low;
  wire src_wdog = watchdog_enable & watchdog_timeout;
  wire src_opcode = bad_opcode | (stop_instr & ~stop_allow)
                    | (debug_halt_instr & ~debug_halt_allow);
  wire src_addr = bad_address;
  wire other_reset = src_pin | src_wdog | src_opcode | src_addr;
  logic [7:0] other_cause;
  always_comb begin
    other_cause = rcpw_pkg::CAUSE_NONE;
    other_cause[rcpw_pkg::CAUSE_PIN] = src_pin;
    other_cause[rcpw_pkg::CAUSE_WATCHDOG] = src_wdog;
    other_cause[rcpw_pkg::CAUSE_OPCODE] = src_opcode;
    other_cause[rcpw_pkg::CAUSE_ADDRESS] = src_addr;
  end
  wire any_reset = debug_forced_reset_cmd | supply_reset | other_reset;
  logic reset_hold;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      cause <= rcpw_pkg::CAUSE_AT_POWER_ON;
      reset_hold <= 1'b0;
      system_reset <= 1'b0;
    end else begin
      // Latch only at reset entry; a source held active is not re-counted
      reset_hold <= any_reset;
      system_reset <= any_reset;
      if (any_reset & ~reset_hold) begin
        if (debug_forced_reset_cmd) begin
          cause <= rcpw_pkg::CAUSE_NONE;
        end else if (supply_reset) begin
          cause <= rcpw_pkg::CAUSE_AT_LOW_SUPPLY;
        end else begin
          cause <= other_cause;
        end
      end
    end
  end

  // ----------------------------------------
  // Low-supply interrupt path
  // ----------------------------------------
  wire supply_irq_cond = power.detect_enable & power.irq_enable & ~power.reset_enable
                         & supply_is_low;
  wire supply_event = supply_irq_cond & ~lowsupply_flag;
  wire supply_ack = wr_power & avs_writedata[rcpw_pkg::ACK_BIT];
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      lowsupply_flag <= 1'b0;
    end else if (supply_irq_cond) begin
      lowsupply_flag <= 1'b1;
    end else if (supply_ack) begin
      lowsupply_flag <= 1'b0;
    end
  end

  // ----------------------------------------
  // Periodic wake tick source
  // ----------------------------------------
  // The 32 kHz permission is frozen at stop entry; changing the bits while
  // stopped has no effect until the next stop.
  logic stop_d;
  logic keep_32k;
  logic [4:0] div32;
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      stop_d <= 1'b0;
      keep_32k <= 1'b0;
    end else begin
      stop_d <= stop_mode;
      if (stop_mode & ~stop_d) begin
        keep_32k <= power.detect_enable & power.stop_enable;
      end
    end
  end
  wire run_32k = ~stop_mode | keep_32k;
  wire tick_32k = run_32k & rise_32k;
  wire div_wrap = tick_32k & (div32 == rcpw_pkg::DIV32_LAST);
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      div32 <= 5'h00;
    end else if (tick_32k) begin
      div32 <= div32 + 5'h01;
    end
  end
  wire tick = pwake.clock_select ? div_wrap : rise_1k;

  // ----------------------------------------
  // Periodic wake counter
  // ----------------------------------------
  logic [10:0] period_last;
  always_comb begin
    unique case (pwake.rate)
      3'h1: period_last = rcpw_pkg::PERIOD_LAST_R1;
      3'h2: period_last = rcpw_pkg::PERIOD_LAST_R2;
      3'h3: period_last = rcpw_pkg::PERIOD_LAST_R3;
      3'h4: period_last = rcpw_pkg::PERIOD_LAST_R4;
      3'h5: period_last = rcpw_pkg::PERIOD_LAST_R5;
      3'h6: period_last = rcpw_pkg::PERIOD_LAST_R6;
      3'h7: period_last = rcpw_pkg::PERIOD_LAST_R7;
      3'h0: period_last = rcpw_pkg::PERIOD_LAST_R7; // Unused: counter held off
    endcase
  end
  wire timer_on = pwake.rate != rcpw_pkg::RATE_OFF;
  logic [10:0] pcount;
  wire period_done = timer_on & tick & (pcount >= period_last);
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      pcount <= 11'h000;
    end else if (!timer_on | wr_pwake | period_done) begin
      pcount <= 11'h000;
    end else if (tick) begin
      pcount <= pcount + 11'h001;
    end
  end
  wire pwake_ack = wr_pwake & avs_writedata[rcpw_pkg::ACK_BIT];
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      pwake_flag <= 1'b0;
    end else if (period_done) begin
      pwake_flag <= 1'b1;
    end else if (pwake_ack) begin
      pwake_flag <= 1'b0;
    end
  end
  wire pwake_event = period_done & pwake.irq_enable;

  // ----------------------------------------
  // Interrupt status, mask and output
  // ----------------------------------------
  logic [1:0] events;
  assign events[rcpw_pkg::IRQ_LOW_SUPPLY] = supply_event;
  assign events[rcpw_pkg::IRQ_PERIODIC] = pwake_event;
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      irq_status <= 2'b00;
    end else begin
      // A new event in the clearing read's cycle stays set
      irq_status <= (rd_istat ? 2'b00 : irq_status) | events;
    end
  end
  assign irq = |(irq_status & irq_mask);
endmodule // rcpw_top
`default_nettype wire

// ==== test/rcpw_top_props.sv ====
// Checker: bus timing, reset requests and watchdog clear
`timescale 1ns/1ps
`default_nettype none
module rcpw_props (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic irq,
  input wire logic watchdog_enable,
  input wire logic watchdog_timeout,
  input wire logic bad_opcode,
  input wire logic stop_instr,
  input wire logic stop_allow,
  input wire logic debug_halt_instr,
  input wire logic debug_halt_allow,
  input wire logic bad_address,
  input wire logic debug_forced_reset_cmd,
  input wire logic system_reset,
  input wire logic watchdog_clear
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  wire logic cause_hit = (avs_address == rcpw_pkg::ADDR_CAUSE) && !avs_waitrequest;
  // ----
  // Properties
  // ----
  a_wait_one: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("waitrequest held longer than one cycle");
  a_wait_first: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest)
    else $error("request answered without a wait state");
  a_wdog_pulse: assert property (avs_write && cause_hit |=> watchdog_clear ##1 !watchdog_clear)
    else $error("watchdog clear pulse wrong");
  a_wdog_cause: assert property (watchdog_clear |-> $past(avs_write && cause_hit))
    else $error("watchdog clear without a cause write");
  a_debug_rst: assert property (debug_forced_reset_cmd |=> system_reset)
    else $error("debug reset not requested");
  a_wdog_rst: assert property (watchdog_enable && watchdog_timeout |=> system_reset)
    else $error("watchdog reset not requested");
  a_opcode_rst: assert property (bad_opcode || (stop_instr && !stop_allow)
    || (debug_halt_instr && !debug_halt_allow) |=> system_reset) else $error("opcode reset missing");
  a_addr_rst: assert property (bad_address |=> system_reset)
    else $error("address reset not requested");
  a_cause_zero: assert property (avs_read && cause_hit |-> avs_readdata[2] == 1'b0
    && avs_readdata[0] == 1'b0 && avs_readdata[31:8] == 24'h000000) else $error("unused bits set");
  c_wdog: cover property (watchdog_clear);
  c_irq: cover property (irq && !system_reset);
  c_rst: cover property (system_reset ##1 !system_reset);
endmodule // rcpw_props
`default_nettype wire

// ==== test/rcpw_top_test.sv ====
// Testbench: reset cause, low-supply interrupt and periodic wake
`timescale 1ns/1ps
`default_nettype none
module rcpw_top_test;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [4:0] avs_address = 5'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h00000000;
  logic [31:0] avs_readdata;
  logic avs_waitrequest, irq, system_reset, watchdog_clear, lowsupply_flag;
  logic stop_mode = 1'b0;
  // Source order: pin en, pin low, wdog en, timeout, opcode, stop, stop ok, halt, halt ok,
  // address, supply low, debug command
  logic [11:0] src = 12'h000;
  logic [2:0] rcnt = 3'h0;
  logic [7:0] expq[$];
  logic [31:0] seed = 32'hdf527e60;
  int err_count = 0;
  int check_count = 0;
  int wdc = 0;
  int pl[8] = '{0, 8, 32, 64, 128, 256, 512, 1024};
  rcpw_top i_dut (.sys_clk(sys_clk), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'hf), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .irq(irq), .pin_reset_n(!src[10]), .supply_low(src[1]), .ref_1khz(rcnt[2]),
    .ref_32khz(rcnt[1]), .reset_pin_enable(src[11]), .watchdog_enable(src[9]),
    .watchdog_timeout(src[8]), .bad_opcode(src[7]), .stop_instr(src[6]), .stop_allow(src[5]),
    .debug_halt_instr(src[4]), .debug_halt_allow(src[3]), .bad_address(src[2]),
    .debug_forced_reset_cmd(src[0]), .stop_mode(stop_mode), .system_reset(system_reset),
    .watchdog_clear(watchdog_clear), .lowsupply_flag(lowsupply_flag));
  // ----
  // Clock, references, monitor
  // ----
  // References run much faster than real life so every rate fits in the run
  always #12.5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) rcnt <= rcnt + 3'h1;
  always @(posedge sys_clk) if (watchdog_clear === 1'b1) wdc++;
  always @(posedge sys_clk) begin
    if (avs_read && avs_waitrequest === 1'b0 && expq.size() > 0)
      chk(avs_readdata, {24'h000000, expq.pop_front()});
  end
  // ----
  // Tasks
  // ----
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  task chk(input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      err_count++;
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, s, e);
    end
  endtask
  task bus(input logic w, input logic [4:0] a, input logic [7:0] d);
    avs_address <= a;
    avs_writedata <= {24'h000000, d};
    avs_write <= w;
    avs_read <= !w;
    @(posedge sys_clk iff avs_waitrequest === 1'b0);
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge sys_clk);
  endtask
  task rd(input logic [4:0] a, input logic [7:0] e);
    expq.push_back(e);
    bus(1'b0, a, 8'h00);
  endtask
  task src_case(input logic [11:0] p, input logic r, input logic [7:0] c);
    src <= p;
    repeat (6) @(posedge sys_clk);
    chk(system_reset, r);
    src <= 12'h000;
    repeat (8) @(posedge sys_clk);
    rd(rcpw_pkg::ADDR_CAUSE, c);
  endtask
  task per(input logic [7:0] cfg, input int c, input int tol);
    int n;
    n = 0;
    bus(1'b1, rcpw_pkg::ADDR_PWAKE, cfg | 8'h40);
    while (irq !== 1'b1 && n < 10000) begin
      @(posedge sys_clk);
      n++;
    end
    chk(n >= c - tol && n <= c + tol, 1'b1);
    rd(rcpw_pkg::ADDR_IRQ_STATUS, 8'h02);
  endtask
  task give_verdict;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // ----
  // Scenarios
  // ----
  initial begin
    repeat (10) @(posedge sys_clk);
    rst_n <= 1'b1;
    rd(5'h00, 8'h82);
    rd(5'h04, 8'h14);
    rd(5'h08, 8'h00);
    rd(5'h0c, 8'h00);
    rd(5'h10, 8'h00);
    rd(5'h14, 8'h00);
    seed = xs(seed);
    bus(1'b1, 5'h00, seed[7:0]);
    bus(1'b1, 5'h1c, seed[15:8]);
    rd(5'h00, 8'h82);
    chk(wdc, 1);
    $display("test reset values done");
    src_case(12'hc00, 1'b1, 8'h40);
    src_case(12'h300, 1'b1, 8'h20);
    src_case(12'h100, 1'b0, 8'h20);
    src_case(12'h080, 1'b1, 8'h10);
    src_case(12'h004, 1'b1, 8'h08);
    src_case(12'h040, 1'b1, 8'h10);
    src_case(12'h001, 1'b1, 8'h00);
    src_case(12'h010, 1'b1, 8'h10);
    src_case(12'h068, 1'b0, 8'h10);
    src_case(12'h002, 1'b1, 8'h02);
    src_case(12'h304, 1'b1, 8'h28);
    // Power-on again must drop the recorded causes
    rst_n <= 1'b0;
    repeat (10) @(posedge sys_clk);
    rst_n <= 1'b1;
    rd(5'h00, 8'h82);
    $display("test reset causes done");
    bus(1'b1, 5'h04, 8'h24);
    src <= 12'h002;
    repeat (8) @(posedge sys_clk);
    chk(lowsupply_flag, 1'b1);
    chk(irq, 1'b0);
    chk(system_reset, 1'b0);
    bus(1'b1, 5'h10, 8'h03);
    chk(irq, 1'b1);
    rd(5'h0c, 8'h01);
    chk(irq, 1'b0);
    src <= 12'h000;
    repeat (4) @(posedge sys_clk);
    bus(1'b1, 5'h04, 8'h64);
    rd(5'h04, 8'h24);
    $display("test low supply done");
    for (int k = 1; k < 8; k++) per(8'h10 | 8'(k), pl[k] * 8, 16);
    per(8'h31, 1024, 200);
    bus(1'b1, 5'h08, 8'h41);
    repeat (200) @(posedge sys_clk);
    chk(irq, 1'b0);
    rd(5'h08, 8'h81);
    bus(1'b1, 5'h08, 8'h50);
    // Longer than the slowest 1 kHz period, so a timer left running would show
    repeat (8400) @(posedge sys_clk);
    chk(irq, 1'b0);
    rd(5'h08, 8'h10);
    $display("test periodic rates done");
    stop_mode <= 1'b1;
    per(8'h11, 64, 16);
    bus(1'b1, 5'h08, 8'h71);
    repeat (1400) @(posedge sys_clk);
    chk(irq, 1'b0);
    stop_mode <= 1'b0;
    bus(1'b1, 5'h04, 8'h2c);
    stop_mode <= 1'b1;
    per(8'h31, 1024, 200);
    stop_mode <= 1'b0;
    $display("test stop mode done");
    give_verdict;
  end
  initial begin
    repeat (60000) @(posedge sys_clk);
    err_count++;
    give_verdict;
  end
endmodule // rcpw_top_test
bind rcpw_top rcpw_props i_props (.sys_clk(sys_clk), .rst_n(rst_n), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .irq(irq), .watchdog_enable(watchdog_enable),
  .watchdog_timeout(watchdog_timeout), .bad_opcode(bad_opcode), .stop_instr(stop_instr),
  .stop_allow(stop_allow), .debug_halt_instr(debug_halt_instr),
  .debug_halt_allow(debug_halt_allow), .bad_address(bad_address),
  .debug_forced_reset_cmd(debug_forced_reset_cmd), .system_reset(system_reset),
  .watchdog_clear(watchdog_clear));
`default_nettype wire
